// ===== mbd_regs.vh
// register map, field positions and timing constants of the bias current detector
// Summary of operation
// [RQ1] bias reference on only while supply enable set
// [RQ2] detection runs only while detect enable set
// [RQ3] insertion threshold field bits 5:4, reset 00
// [RQ4] button threshold field bits 3:2, reset 00
// [RQ5] both crossings feed interrupt logic separately
// [RQ6] steady insertion and button status to pin
// [RQ7] separate assert and release comparator levels
// [RQ8] button valid after ten consecutive measurements
// [RQ9] polarity 0: insertion sets insertion flag
// [RQ10] polarity 1: removal sets insertion flag
// [RQ11] polarity 0: filtered press sets button flag
// [RQ12] polarity 1: release sets button flag
// [RQ13] events and pin status share bounded latency
// [RQ14] host waits past bounce before flipping polarity
// [RQ15] host debounces the status pin itself
// [RQ16] filter runs only with all clock gates
// [RQ17] events during clock loss flagged after restore
// [RQ18] comparators sampled once per measurement tick
// [RQ19] event flags sticky until software clears
`ifndef MBD_REGS_VH
`define MBD_REGS_VH

// ----------------------------------------------------------------
// register word indices (printed offsets not all word aligned: byte address = index * 4)
// ----------------------------------------------------------------
`define MBD_IDX_BIAS_CTRL 8'h06
`define MBD_IDX_CLK_RATES 8'h16
`define MBD_IDX_SEQ_CTRL0 8'h6c
`define MBD_IDX_STATUS 8'h70
`define MBD_IDX_MASK 8'h71
`define MBD_IDX_POLARITY 8'h72
`define MBD_IDX_LIVE 8'h73

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MBD_BIAS_ENA_BIT 0
`define MBD_DET_ENA_BIT 1
`define MBD_BTN_THR_LSB 2
`define MBD_INS_THR_LSB 4
`define MBD_CLK_SYS_BIT 2
`define MBD_SEQ_CLK_BIT 8
`define MBD_EV_INS_BIT 0
`define MBD_EV_BTN_BIT 1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define MBD_CTRL_RST 16'h0000
`define MBD_EV_RST 2'h0
`define MBD_TICK_NS 1000
`define MBD_CLK_NS 10
`define MBD_TICK_CYC (`MBD_TICK_NS / `MBD_CLK_NS)
`define MBD_BTN_COUNT 4'ha

`endif

// ===== mbd_detect.v
// bias current detector: wishbone registers, hysteresis, button filter, event flags
`timescale 1ns/1ns
`default_nettype none
`include "mbd_regs.vh"

module mbd_detect (
    input wire clock,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire mclk_present,
    input wire ins_cmp_hi,
    input wire ins_cmp_lo,
    input wire btn_cmp_hi,
    input wire btn_cmp_lo,
    output reg bias_reference_pin,
    output reg current_detect_enable,
    output reg [1:0] insertion_threshold_select,
    output reg [1:0] button_threshold_select,
    output reg ins_status_pin,
    output reg btn_status_pin,
    output reg ins_cross_event,
    output reg btn_cross_event,
    output reg irq
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [15:0] bias_ctrl_r;
reg [15:0] clk_rates_r;
reg [15:0] seq_ctrl_r;
reg [1:0] status_r;
reg [1:0] mask_r;
reg [1:0] polarity_r;
reg ins_state_r;
reg btn_raw_r;
reg btn_state_r;
reg [3:0] btn_cnt_r;
reg [6:0] tick_cnt_r;
reg tick_r;

wire [7:0] idx = wb_adr_i[9:2];
wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr_lo = req & wb_we_i & wb_sel_i[0];
wire wr_hi = req & wb_we_i & wb_sel_i[1];
wire clocks_ok = mclk_present & clk_rates_r[`MBD_CLK_SYS_BIT]
    & seq_ctrl_r[`MBD_SEQ_CLK_BIT]; // RQ16
wire det_run = clocks_ok & bias_ctrl_r[`MBD_DET_ENA_BIT]; // RQ2

// byte-lane merge of a 16-bit register
function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input lo;
    input hi;
    begin
        merge16 = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
    end
endfunction

// ----------------------------------------------------------------
// bus slave: one-wait answer, unmapped reads return zero
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= req;
        wb_dat_o <= 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (idx)
                `MBD_IDX_BIAS_CTRL: wb_dat_o <= {16'h0000, bias_ctrl_r};
                `MBD_IDX_CLK_RATES: wb_dat_o <= {16'h0000, clk_rates_r};
                `MBD_IDX_SEQ_CTRL0: wb_dat_o <= {16'h0000, seq_ctrl_r};
                `MBD_IDX_STATUS: wb_dat_o <= {30'h0, status_r};
                `MBD_IDX_MASK: wb_dat_o <= {30'h0, mask_r};
                `MBD_IDX_POLARITY: wb_dat_o <= {30'h0, polarity_r};
                `MBD_IDX_LIVE: wb_dat_o <= {30'h0, btn_state_r, ins_state_r};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
end

// control registers; only the documented fields are kept in the control word
always @(posedge clock) begin
    if (rst) begin
        bias_ctrl_r <= `MBD_CTRL_RST; // RQ3 RQ4
        clk_rates_r <= `MBD_CTRL_RST;
        seq_ctrl_r <= `MBD_CTRL_RST;
        mask_r <= `MBD_EV_RST;
        polarity_r <= `MBD_EV_RST;
    end else begin
        if (idx == `MBD_IDX_BIAS_CTRL)
            bias_ctrl_r <= merge16(bias_ctrl_r, wb_dat_i, wr_lo, wr_hi) & 16'h003f;
        if (idx == `MBD_IDX_CLK_RATES)
            clk_rates_r <= merge16(clk_rates_r, wb_dat_i, wr_lo, wr_hi);
        if (idx == `MBD_IDX_SEQ_CTRL0)
            seq_ctrl_r <= merge16(seq_ctrl_r, wb_dat_i, wr_lo, wr_hi);
        if (idx == `MBD_IDX_MASK && wr_lo)
            mask_r <= wb_dat_i[1:0];
        if (idx == `MBD_IDX_POLARITY && wr_lo)
            polarity_r <= wb_dat_i[1:0];
    end
end

// ----------------------------------------------------------------
// measurement tick: counter only advances with clocks present
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst || !det_run) begin
        tick_cnt_r <= 7'h00;
        tick_r <= 1'b0;
    end else if ({25'h0, tick_cnt_r} == (`MBD_TICK_CYC) - 1) begin
        tick_cnt_r <= 7'h00;
        tick_r <= 1'b1; // RQ18
    end else begin
        tick_cnt_r <= tick_cnt_r + 7'h01;
        tick_r <= 1'b0;
    end
end

// ----------------------------------------------------------------
// hysteresis and button filter; state frozen, not cleared, while clocks
// are missing so a change during the gap is seen on the next tick
// ----------------------------------------------------------------
reg ins_next;
reg btn_raw_next;
always @* begin
    // rise on the high comparator, fall only below the low one
    ins_next = ins_state_r ? ins_cmp_lo : ins_cmp_hi; // RQ7
    btn_raw_next = btn_raw_r ? btn_cmp_lo : btn_cmp_hi; // RQ7
end

wire btn_flip = tick_r && (btn_raw_next != btn_state_r);
wire ins_rise = tick_r && ins_next && !ins_state_r;
wire ins_fall = tick_r && !ins_next && ins_state_r;
wire btn_rise = btn_flip && btn_cnt_r == `MBD_BTN_COUNT - 4'h1 && btn_raw_next;
wire btn_fall = btn_flip && btn_cnt_r == `MBD_BTN_COUNT - 4'h1 && !btn_raw_next;

always @(posedge clock) begin
    if (rst) begin
        ins_state_r <= 1'b0;
        btn_raw_r <= 1'b0;
        btn_state_r <= 1'b0;
        btn_cnt_r <= 4'h0;
    end else if (tick_r) begin
        ins_state_r <= ins_next; // RQ17
        btn_raw_r <= btn_raw_next;
        // any measurement agreeing with the settled state restarts the run
        if (!btn_flip)
            btn_cnt_r <= 4'h0; // RQ8
        else if (btn_cnt_r == `MBD_BTN_COUNT - 4'h1) begin
            btn_cnt_r <= 4'h0;
            btn_state_r <= btn_raw_next; // RQ8
        end else
            btn_cnt_r <= btn_cnt_r + 4'h1;
    end
end

// ----------------------------------------------------------------
// sticky flags: set wins over write-one-to-clear
// ----------------------------------------------------------------
wire ins_evt = polarity_r[`MBD_EV_INS_BIT] ? ins_fall : ins_rise; // RQ9 RQ10
wire btn_evt = polarity_r[`MBD_EV_BTN_BIT] ? btn_fall : btn_rise; // RQ11 RQ12
wire [1:0] w1c = (idx == `MBD_IDX_STATUS && wr_lo) ? wb_dat_i[1:0] : 2'h0;
wire [1:0] status_nxt = (status_r & ~w1c) | {btn_evt, ins_evt}; // RQ19

always @(posedge clock) begin
    if (rst) begin
        status_r <= `MBD_EV_RST;
        irq <= 1'b0;
        ins_cross_event <= 1'b0;
        btn_cross_event <= 1'b0;
    end else begin
        status_r <= status_nxt; // RQ19
        irq <= |(status_nxt & mask_r);
        ins_cross_event <= ins_rise | ins_fall; // RQ5
        btn_cross_event <= btn_rise | btn_fall; // RQ5
    end
end

// ----------------------------------------------------------------
// analog controls and status pins, all registered
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        bias_reference_pin <= 1'b0;
        current_detect_enable <= 1'b0;
        insertion_threshold_select <= 2'h0;
        button_threshold_select <= 2'h0;
        ins_status_pin <= 1'b0;
        btn_status_pin <= 1'b0;
    end else begin
        bias_reference_pin <= bias_ctrl_r[`MBD_BIAS_ENA_BIT]; // RQ1
        current_detect_enable <= bias_ctrl_r[`MBD_DET_ENA_BIT]; // RQ2
        insertion_threshold_select <= bias_ctrl_r[`MBD_INS_THR_LSB +: 2]; // RQ3
        button_threshold_select <= bias_ctrl_r[`MBD_BTN_THR_LSB +: 2]; // RQ4
        // pin follows the same settled state the flags use
        ins_status_pin <= ins_state_r; // RQ6 RQ13
        btn_status_pin <= btn_state_r; // RQ6
    end
end

endmodule
`default_nettype wire

// ===== mbd_asserts.sv
// port assertions for the bias current detector
`timescale 1ns/1ns
`default_nettype none
module mbd_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic mclk_present,
    input wire logic btn_cmp_hi,
    input wire logic bias_reference_pin,
    input wire logic current_detect_enable,
    input wire logic [1:0] insertion_threshold_select,
    input wire logic [1:0] button_threshold_select,
    input wire logic ins_status_pin,
    input wire logic btn_status_pin,
    input wire logic ins_cross_event,
    input wire logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----
    // control fields, filter, clock loss, sticky flags
    // ----
    // control write taken; the register lands, then the pins follow
    wire logic wr = wb_ack_o & wb_we_i & (wb_adr_i == 10'h018);
    property p_bias; wr |-> ##2 bias_reference_pin == $past(wb_dat_i[0], 2); endproperty
    a_bias: assert property (p_bias) else $error("bias pin");
    property p_det; wr |-> ##2 current_detect_enable == $past(wb_dat_i[1], 2); endproperty
    a_det: assert property (p_det) else $error("detect enable");
    property p_ithr; wr |-> ##2 insertion_threshold_select == $past(wb_dat_i[5:4], 2);
    endproperty
    a_ithr: assert property (p_ithr) else $error("insertion level");
    property p_bthr; wr |-> ##2 button_threshold_select == $past(wb_dat_i[3:2], 2);
    endproperty
    a_bthr: assert property (p_bthr) else $error("button level");
    property p_pulse; ins_cross_event |=> !ins_cross_event; endproperty
    a_pulse: assert property (p_pulse) else $error("crossing pulse");
    // ten samples a tick apart span at least nine tick periods
    property p_filt; $rose(btn_status_pin) |-> $past(btn_cmp_hi, 900); endproperty
    a_filt: assert property (p_filt) else $error("button filter");
    property p_hold; !mclk_present [*4] |-> $stable(ins_status_pin) && $stable(btn_status_pin);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved without clock");
    // the interrupt may only drop in the cycle after one with wb_cyc_i high, whether read or write
    property p_stick; irq && !wb_cyc_i |=> irq; endproperty
    a_stick: assert property (p_stick) else $error("irq dropped");
endmodule
bind mbd_detect mbd_asserts u_chk (.*);
`default_nettype wire

// ===== mbd_jack.sv
// headset accessory: bias current seen through assert and release comparators
`timescale 1ns/1ns
`default_nettype none
module mbd_jack (
    input wire logic clock,
    input wire logic mic,
    input wire logic press,
    output logic ins_cmp_hi,
    output logic ins_cmp_lo,
    output logic btn_cmp_hi,
    output logic btn_cmp_lo
);
    logic mic_r = 1'b0;
    logic prs_r = 1'b0;
    // current ramps: the release level is passed first on the way up, last on the way down
    always @(posedge clock) begin
        mic_r <= mic;
        prs_r <= mic & press;
    end
    assign ins_cmp_lo = mic | mic_r;
    assign ins_cmp_hi = mic & mic_r;
    assign btn_cmp_lo = (mic & press) | prs_r;
    assign btn_cmp_hi = mic & press & prs_r;
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the bias current detector
`timescale 1ns/1ns
`default_nettype none
`include "mbd_regs.vh"
module testbench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic mclk = 1'b1;
    logic mic = 1'b0;
    logic prs = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wd = 32'h0000_0000;
    logic [15:0] rnd = 16'hf22b;
    logic [31:0] exp_q[$];
    int fail_count = 0;
    int n_tests = 0;
    wire logic ih, il, bh, bl, ack, irq;
    wire logic [31:0] rdat;
    mbd_jack u_jack (.clock(clock), .mic(mic), .press(prs), .ins_cmp_hi(ih), .ins_cmp_lo(il),
        .btn_cmp_hi(bh), .btn_cmp_lo(bl));
    mbd_detect DUT (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mclk_present(mclk), .ins_cmp_hi(ih), .ins_cmp_lo(il), .btn_cmp_hi(bh),
        .btn_cmp_lo(bl), .bias_reference_pin(), .current_detect_enable(),
        .insertion_threshold_select(), .button_threshold_select(), .ins_status_pin(),
        .btn_status_pin(), .ins_cross_event(), .btn_cross_event(), .irq(irq));
    always #5 clock = ~clock;
    // ----
    // bus tasks and checking
    // ----
    task automatic bw(input logic [9:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clock); while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bw(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic wt(input int n);
        repeat (n * `MBD_TICK_CYC) @(posedge clock);
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED read data expected %h seen %h", e, g);
        end
    endtask
    // interrupt line is a settled level long after the flag write, so compare it directly
    task automatic chk_irq(input logic e);
        n_tests++;
        if (irq !== e) begin
            fail_count++;
            $display("CHECK FAILED irq expected %b seen %b", e, irq);
        end
    endtask
    // stimulus source, seeded once at its declaration above
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ack stands one cycle, so the middle of it is a settled place to compare
    always @(negedge clock) begin
        if (ack === 1'b1 && we === 1'b0) chk(exp_q.pop_front(), rdat);
    end
    // about fifty ticks of traffic are expected; eight times that means a hang
    initial begin
        #400000;
        fail_count++;
        results;
    end
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(10'h018, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            bw(10'h018, 1'b1, {26'h0, rnd[5:0]});
            rd(10'h018, {26'h0, rnd[5:0]});
        end
        rd(10'h3fc, 32'h0000_0000);
        bw(10'h058, 1'b1, 32'h0000_0004);
        bw(10'h1b0, 1'b1, 32'h0000_0100);
        bw(10'h018, 1'b1, 32'h0000_0003);
        bw(10'h1c4, 1'b1, 32'h0000_0003);
        mic <= 1'b1;
        wt(3);
        rd(10'h1c0, 32'h0000_0001);
        chk_irq(1'b1);
        bw(10'h1c0, 1'b1, 32'h0000_0003);
        rd(10'h1c0, 32'h0000_0000);
        chk_irq(1'b0);
        // a press of five ticks must be filtered away
        prs <= 1'b1;
        wt(5);
        prs <= 1'b0;
        wt(5);
        rd(10'h1c0, 32'h0000_0000);
        prs <= 1'b1;
        wt(12);
        rd(10'h1c0, 32'h0000_0002);
        rd(10'h1cc, 32'h0000_0003);
        bw(10'h1c8, 1'b1, 32'h0000_0003);
        bw(10'h1c0, 1'b1, 32'h0000_0003);
        mic <= 1'b0;
        prs <= 1'b0;
        wt(13);
        rd(10'h1c0, 32'h0000_0003);
        rd(10'h1c8, 32'h0000_0003);
        bw(10'h1c8, 1'b1, 32'h0000_0000);
        bw(10'h1c0, 1'b1, 32'h0000_0003);
        mclk <= 1'b0;
        mic <= 1'b1;
        wt(3);
        rd(10'h1c0, 32'h0000_0000);
        mclk <= 1'b1;
        wt(3);
        rd(10'h1c0, 32'h0000_0001);
        results;
    end
endmodule
`default_nettype wire
